// >>> core/conv_ctrl_pkg.sv
// Package: constants for the simultaneous conversion control block.
// Assumes a 125 MHz pclk and an APB master with 32-bit data.
package conv_ctrl_pkg;

  localparam int          CLK_MHZ        = 125;
  localparam int          NUM_CH         = 8;
  localparam int          RES_BITS       = 16;
  // Conversion time in ns, default budget for all channels
  localparam int          CONV_TIME_NS   = 500;
  localparam int          CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  // Partial reset pulse on the register bus, cycles
  localparam int          PRST_CYCLES    = 1;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF       = 12'h000;
  localparam logic [11:0] STATUS_OFF     = 12'h004;
  localparam logic [11:0] BW_OFF         = 12'h008;
  localparam logic [11:0] UNI_OFF        = 12'h00C;
  localparam logic [11:0] COUNT_OFF      = 12'h010;
  localparam logic [11:0] DATA_BASE_OFF  = 12'h020;

  // Control field positions
  localparam int          CTRL_SWSTART   = 0;
  localparam int          CTRL_EXTCLK    = 1;
  localparam int          CTRL_PRESET    = 2;

  // Status field positions
  localparam int          ST_BUSY        = 0;
  localparam int          ST_SWMODE      = 1;
  localparam int          ST_INTREF      = 2;
  localparam int          ST_EXTCLK      = 3;
  localparam int          ST_VALID       = 4;

  // Reset values
  localparam logic [7:0]  BW_RST         = 8'h00;
  localparam logic [7:0]  UNI_RST        = 8'h00;
  // Edges after reset until the reference pin level has crossed the synchroniser
  localparam logic [1:0]  REF_WAIT_RST   = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_STORE
  } conv_state_t;

endpackage

// >>> core/result_mem.sv
// Result store: DEPTH 16-bit words (eight by default, two banks of one per channel in conv_ctrl), registered read.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
module result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// >>> core/conv_ctrl.sv
// Conversion control for an eight-channel simultaneous-sampling converter.
// Assumes an APB master on pclk, asynchronous pins synchronised here, and
// a SAR data source delivering one raw offset-binary sample per channel.
`timescale 1ns/100ps
module conv_ctrl #(
  parameter int NUM_CH      = conv_ctrl_pkg::NUM_CH,
  parameter int RES_BITS    = conv_ctrl_pkg::RES_BITS,
  parameter int CONV_CYCLES = conv_ctrl_pkg::CONV_CYCLES,
  parameter int EXT_EDGES   = conv_ctrl_pkg::RES_BITS
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       conversion_start_input,
  input  wire logic [2:0]                 oversampling_ratio_pins,
  input  wire logic                       ref_select,
  input  wire logic [NUM_CH*RES_BITS-1:0] sample_data,
  output logic                            busy,
  output logic                            sample_hold,
  output logic                            internal_ref_en,
  output logic                            reference_io_pin_oe,
  output logic      [NUM_CH-1:0]          high_bw_sel
);

  localparam int CW = $clog2(NUM_CH);

  typedef struct packed {
    logic [2:0]                 start_sync;
    logic [2:0]                 os_s1;
    logic [2:0]                 os_s2;
    logic                       ref_s1;
    logic                       ref_s2;
    logic [1:0]                 ref_wait;
    logic                       int_ref;
    conv_ctrl_pkg::conv_state_t state;
    logic [15:0]                cnt;
    logic [CW-1:0]              ch;
    logic [NUM_CH*RES_BITS-1:0] shadow;
    logic                       ext_clk_en;
    logic                       sw_start;
    logic [NUM_CH-1:0]          bw;
    logic [NUM_CH-1:0]          uni;
    logic                       data_valid;
    logic [31:0]                set_count;
    logic                       busy;
    logic                       hold;
    logic                       prst;
    logic [31:0]                prdata;
    logic                       rd_mem;
    logic                       bank;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic state_t reset_state();
    reset_state          = '0;
    reset_state.ref_wait = conv_ctrl_pkg::REF_WAIT_RST;
    reset_state.bw       = NUM_CH'(conv_ctrl_pkg::BW_RST);
    reset_state.uni      = NUM_CH'(conv_ctrl_pkg::UNI_RST);
    reset_state.state    = conv_ctrl_pkg::ST_IDLE;
  endfunction

  localparam state_t S_RST = reset_state();

  logic [RES_BITS-1:0] mem_rdata;
  logic                mem_we;
  logic [CW:0]         mem_raddr;
  logic [CW:0]         mem_waddr;
  logic [RES_BITS-1:0] mem_wdata;
  logic                start_rise;
  logic                sw_mode;
  logic                ext_edge;
  logic                wr_en;
  logic                rd_en;
  logic                is_data;

  // Raw SAR sample is offset binary; bipolar flips the sign bit
  function automatic logic [RES_BITS-1:0] encode(input logic [RES_BITS-1:0] raw,
                                                 input logic                unipolar);
    encode = unipolar ? raw : {~raw[RES_BITS-1], raw[RES_BITS-2:0]};
  endfunction

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] base,
                                    input int          n);
    in_range = (a >= base) && (a < base + 12'(n * 4));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode

  assign sw_mode    = &s_r.os_s2;
  assign start_rise = s_r.start_sync[1] & ~s_r.start_sync[2];
  assign ext_edge   = sw_mode & s_r.ext_clk_en & start_rise;
  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & ~penable & ~pwrite;
  assign is_data    = in_range(paddr, conv_ctrl_pkg::DATA_BASE_OFF, NUM_CH);
  // Reads see the finished bank, the store fills the other one
  assign mem_raddr  = {s_r.bank, CW'(paddr[11:2] - conv_ctrl_pkg::DATA_BASE_OFF[11:2])};
  assign mem_waddr  = {~s_r.bank, s_r.ch};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt          = s_r;
    mem_we         = 1'b0;
    mem_wdata      = '0;
    s_nxt.start_sync = {s_r.start_sync[1:0], conversion_start_input};
    s_nxt.os_s1    = oversampling_ratio_pins;
    s_nxt.os_s2    = s_r.os_s1;
    s_nxt.ref_s1   = ref_select;
    s_nxt.ref_s2   = s_r.ref_s1;
    s_nxt.sw_start = 1'b0;
    s_nxt.prst     = 1'b0;
    s_nxt.rd_mem   = 1'b0;

    // reference mode caught once the synchroniser holds the pin level
    if (s_r.ref_wait != 2'h0) begin
      s_nxt.ref_wait = s_r.ref_wait - 2'h1;
      if (s_r.ref_wait == 2'h1) begin
        s_nxt.int_ref = s_r.ref_s2;
      end
    end

    if (wr_en) begin
      unique case (paddr)
        conv_ctrl_pkg::CTRL_OFF: begin
          s_nxt.sw_start   = pwdata[conv_ctrl_pkg::CTRL_SWSTART];
          s_nxt.ext_clk_en = pwdata[conv_ctrl_pkg::CTRL_EXTCLK];
          s_nxt.prst       = pwdata[conv_ctrl_pkg::CTRL_PRESET];
        end
        conv_ctrl_pkg::BW_OFF:  s_nxt.bw  = pwdata[NUM_CH-1:0];
        conv_ctrl_pkg::UNI_OFF: s_nxt.uni = pwdata[NUM_CH-1:0];
        default: ;
      endcase
    end

    unique case (s_r.state)
      conv_ctrl_pkg::ST_IDLE: begin
        // start edges begin a set only here; while busy they only pace external clock sets
        if ((start_rise && !(sw_mode && s_r.ext_clk_en)) || s_r.sw_start) begin
          // one hold instant for every channel
          s_nxt.shadow = sample_data;
          s_nxt.hold   = 1'b1;
          s_nxt.busy   = 1'b1;
          s_nxt.cnt    = '0;
          s_nxt.state  = conv_ctrl_pkg::ST_CONV;
        end else if (ext_edge) begin
          s_nxt.shadow = sample_data;
          s_nxt.hold   = 1'b1;
          s_nxt.busy   = 1'b1;
          s_nxt.cnt    = '0;
          s_nxt.state  = conv_ctrl_pkg::ST_CONV;
        end
      end
      conv_ctrl_pkg::ST_CONV: begin
        // external clock edges pace the conversion
        if (sw_mode && s_r.ext_clk_en) begin
          if (ext_edge) begin
            s_nxt.cnt = s_r.cnt + 16'd1;
          end
          if (s_r.cnt >= 16'(EXT_EDGES)) begin
            s_nxt.state = conv_ctrl_pkg::ST_STORE;
            s_nxt.ch    = '0;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 16'd1;
          if (s_r.cnt >= 16'(CONV_CYCLES - 1)) begin
            s_nxt.state = conv_ctrl_pkg::ST_STORE;
            s_nxt.ch    = '0;
          end
        end
      end
      conv_ctrl_pkg::ST_STORE: begin
        // every channel written, used or not
        mem_we    = 1'b1;
        mem_wdata = encode(s_r.shadow[s_r.ch*RES_BITS +: RES_BITS], s_r.uni[s_r.ch]);
        s_nxt.ch  = s_r.ch + CW'(1);
        if (s_r.ch == CW'(NUM_CH - 1)) begin
          // busy falls when all are in
          s_nxt.busy       = 1'b0;
          s_nxt.hold       = 1'b0;
          s_nxt.data_valid = 1'b1;
          s_nxt.set_count  = s_r.set_count + 32'd1;
          s_nxt.bank       = ~s_r.bank;
          s_nxt.state      = conv_ctrl_pkg::ST_IDLE;
        end
      end
      default: s_nxt.state = conv_ctrl_pkg::ST_IDLE;
    endcase

    // partial reset discards the set in flight
    if (s_r.prst) begin
      s_nxt.state = conv_ctrl_pkg::ST_IDLE;
      s_nxt.busy  = 1'b0;
      s_nxt.hold  = 1'b0;
      s_nxt.cnt   = '0;
      s_nxt.ch    = '0;
    end

    // Read data are registered in setup, served in access
    if (rd_en) begin
      s_nxt.prdata = '0;
      unique case (paddr)
        conv_ctrl_pkg::STATUS_OFF: begin
          s_nxt.prdata[conv_ctrl_pkg::ST_BUSY]   = s_r.busy;
          s_nxt.prdata[conv_ctrl_pkg::ST_SWMODE] = sw_mode;
          s_nxt.prdata[conv_ctrl_pkg::ST_INTREF] = s_r.int_ref;
          s_nxt.prdata[conv_ctrl_pkg::ST_EXTCLK] = s_r.ext_clk_en;
          s_nxt.prdata[conv_ctrl_pkg::ST_VALID]  = s_r.data_valid;
        end
        conv_ctrl_pkg::CTRL_OFF:
          s_nxt.prdata[conv_ctrl_pkg::CTRL_EXTCLK] = s_r.ext_clk_en;
        conv_ctrl_pkg::BW_OFF:    s_nxt.prdata[NUM_CH-1:0] = s_r.bw;
        conv_ctrl_pkg::UNI_OFF:   s_nxt.prdata[NUM_CH-1:0] = s_r.uni;
        conv_ctrl_pkg::COUNT_OFF: s_nxt.prdata = s_r.set_count;
        default:                  s_nxt.rd_mem = is_data;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result store
  // two banks, the old set stays readable through the whole busy time
  // banks swap as busy falls, so the full new set shows at once
  // an aborted set never swaps, its partial words stay hidden

  result_mem #(
    .DEPTH (2 * NUM_CH),
    .WIDTH (RES_BITS)
  ) u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Access phase always one cycle; unmapped writes accepted and dropped
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = s_r.rd_mem ? {{(32-RES_BITS){1'b0}}, mem_rdata} : s_r.prdata;

  assign busy        = s_r.busy;
  assign sample_hold = s_r.hold;
  // pin left as input with external reference
  assign internal_ref_en     = s_r.int_ref;
  assign reference_io_pin_oe = s_r.int_ref;
  // code transitions are analog; LSB is range over 65,536
  assign high_bw_sel         = s_r.bw;

endmodule

// >>> tb/conv_host_model.sv
// Host side model: start pin, mode pins and raw channel samples.
// Assumes pclk from the bench; tasks are called just after a rising edge.
`timescale 1ns/100ps
module conv_host_model (
  input  wire logic         pclk,
  output logic              conversion_start_input,
  output logic [2:0]        oversampling_ratio_pins,
  output logic [127:0]      sample_data
);
  initial begin
    conversion_start_input  = 1'b0;
    oversampling_ratio_pins = 3'h7;
    sample_data             = 128'h0;
  end
  ////////////////////////////////////////////////////////////
  task automatic load;
    for (int i = 0; i < 4; i++) sample_data[i*32 +: 32] <= $urandom;
  endtask
  // any other pin pattern keeps hardware mode
  task automatic set_os(input logic [2:0] v);
    oversampling_ratio_pins <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic edges(input int n);
    repeat (n) begin
      conversion_start_input <= 1'b1;
      repeat (2) @(posedge pclk);
      conversion_start_input <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule

// >>> tb/conv_ctrl_assertions.sv
// Checker: busy timing, reference and bandwidth outputs of conv_ctrl.
// Assumes it is bound into conv_ctrl and sees only its ports.
`timescale 1ns/100ps
module conv_ctrl_assertions #(
  parameter int CONV_CYCLES = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        conversion_start_input,
  input wire logic        ref_select,
  input wire logic        busy,
  input wire logic        sample_hold,
  input wire logic        internal_ref_en,
  input wire logic        reference_io_pin_oe,
  input wire logic [7:0]  high_bw_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] busy_cnt_r;
  logic [3:0] up_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_r <= 8'h00;
      up_cnt_r   <= 4'h0;
    end else begin
      busy_cnt_r <= busy ? busy_cnt_r + 8'h01 : 8'h00;
      if (up_cnt_r != 4'hF) up_cnt_r <= up_cnt_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  a_start_busy: assert property (!busy && $rose(conversion_start_input) |-> ##[2:4] busy)
    else $error("busy did not follow start edge");
  a_busy_min: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  // Loose bound: external clock sets stretch busy
  a_busy_max: assert property (int'(busy_cnt_r) <= 16*CONV_CYCLES + 64)
    else $error("busy stuck high");
  a_hold_busy: assert property (sample_hold == busy)
    else $error("hold differs from busy");
  a_ref_pin: assert property (internal_ref_en == reference_io_pin_oe)
    else $error("reference pin enable mismatch");
  a_ref_latch: assert property (up_cnt_r >= 4'h6 |-> $stable(internal_ref_en))
    else $error("reference mode moved after reset");
  a_ref_level: assert property (up_cnt_r == 4'h6 |-> internal_ref_en == ref_select)
    else $error("reference mode wrong");
  a_bw_cause: assert property ($changed(high_bw_sel) |->
    $past(psel && penable && pwrite && paddr == 12'h008))
    else $error("bandwidth select changed alone");
  c_refused: cover property (busy && $rose(conversion_start_input));
  c_read_busy: cover property (busy && psel && penable && !pwrite);
  c_done: cover property ($fell(busy));
endmodule

// >>> tb/simultaneous_adc_conversion_control_tb.sv
// Testbench: APB traffic and start-pin conversions on conv_ctrl.
// Assumes host model and checker are compiled first.
`timescale 1ns/100ps
module simultaneous_adc_conversion_control_tb;
  localparam int CONV_CYCLES = 4;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_select;
  logic         conversion_start_input, busy, sample_hold, internal_ref_en;
  logic         reference_io_pin_oe;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [2:0]   oversampling_ratio_pins;
  logic [127:0] sample_data;
  logic [7:0]   high_bw_sel, bw, uni;
  logic [15:0]  last [8];
  logic [31:0]  exp_q [$];
  int           n_errors, n_compared;

  conv_ctrl #(.CONV_CYCLES(CONV_CYCLES)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .conversion_start_input,
    .oversampling_ratio_pins, .ref_select, .sample_data, .busy, .sample_hold,
    .internal_ref_en, .reference_io_pin_oe, .high_bw_sel);
  conv_host_model i_host (.pclk, .conversion_start_input, .oversampling_ratio_pins,
    .sample_data);

  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input int n);
    exp_q.push_back({16'h0000, last[n]});
    apb(1'b0, 12'h020 + 12'(4 * n), 32'h0);
  endtask
  task automatic rd_all;
    for (int n = 0; n < 8; n++) rd(n);
  endtask
  task automatic capture(input logic [7:0] u);
    for (int n = 0; n < 8; n++)
      last[n] = i_host.sample_data[n*16 +: 16] ^ (u[n] ? 16'h0000 : 16'h8000);
  endtask
  task automatic wait_idle;
    int k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (busy !== 1'b0 && k < 300);
    if (busy !== 1'b0) begin
      n_errors++;
      $display("MISMATCH %0t busy never fell", $time);
      test_done();
    end
    @(posedge pclk);
  endtask
  // Reads are judged when the access phase completes
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) chk(prdata, exp_q.pop_front());
  end
  initial begin
    #40000;
    n_errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    ref_select = 1'b1;
    n_errors   = 0;
    n_compared = 0;
    void'($urandom(13166));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(internal_ref_en), 32'h1);
    bw = 8'($urandom);
    apb(1'b1, 12'h008, {24'h0, bw});
    chk(32'(high_bw_sel), {24'h0, bw});
    exp_q.push_back(32'h0);
    apb(1'b0, 12'h100, 32'h0);
    i_host.load();
    i_host.edges(1);
    wait_idle();
    capture(8'h00);
    rd_all();
    // Second edge lands while busy, read also overlaps busy
    i_host.load();
    i_host.edges(2);
    rd(3);
    wait_idle();
    repeat (8) @(negedge pclk) chk(32'(busy), 32'h0);
    @(posedge pclk);
    capture(8'h00);
    rd_all();
    uni = 8'($urandom);
    apb(1'b1, 12'h00C, {24'h0, uni});
    i_host.load();
    i_host.edges(1);
    wait_idle();
    capture(uni);
    rd_all();
    i_host.load();
    i_host.edges(1);
    repeat (6) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h4);
    wait_idle();
    rd_all();
    apb(1'b1, 12'h000, 32'h2);
    i_host.load();
    i_host.edges(17);
    wait_idle();
    capture(uni);
    rd_all();
    // Hardware mode: external clock bit set but pin edges start timed sets
    i_host.set_os(3'($urandom % 7));
    exp_q.push_back(32'h0000_001C);
    apb(1'b0, 12'h004, 32'h0);
    i_host.load();
    i_host.edges(1);
    wait_idle();
    capture(uni);
    rd_all();
    i_host.load();
    apb(1'b1, 12'h000, 32'h1);
    wait_idle();
    capture(uni);
    rd_all();
    exp_q.push_back(32'h0000_0006);
    apb(1'b0, 12'h010, 32'h0);
    presetn    <= 1'b0;
    ref_select <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(reference_io_pin_oe), 32'h0);
    test_done();
  end
endmodule

bind conv_ctrl conv_ctrl_assertions #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .conversion_start_input, .ref_select, .busy,
  .sample_hold, .internal_ref_en, .reference_io_pin_oe, .high_bw_sel);
